// file: interconnect_error_status_log.sv
// interconnect error status bank with ahb-lite register access
`timescale 1ns/1ps
// How it works
// - errors of banks five, seven, eight are reported via this status layout
// - bits 31:22 carry flag meaning only with model code 12h
// - bit 22 flags a phy control error
// - bit 23 flags an unexpected retry acknowledge flit
// - bit 24 flags an unexpected retry request flit
// - bit 25 flags register-file storage parity error
// - bit 26 flags a routeback table error
// - bit 27 flags an unexpected transmit protocol flit
// - bit 28 flags crossing buffer credit overflow or underflow
// - bit 29 flags active link state reached during link reset
// - bit 30 flags link reset started while traffic not idle
// - bit 31 flags link-layer transmit parity error
// - bits 37:32 info, 56:38 corrected count, 63:57 validity
// - model-specific code sits in bits 21:16, 12h is control error
// - architectural code 0c0f for bad packets, 0e0f otherwise
module interconnect_error_status_log
  import err_log_pkg::*;
#(
  parameter int BANK_ID = 5
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // fault reports from link logic on this clock
  input  wire logic [NFLAG-1:0]     ctrl_flag_pulse,
  input  wire logic                 corrected_pulse,
  input  wire err_log_pkg::fault_rpt_t fault_rpt,
  // link-layer reset status
  input  wire logic                 link_reset_done,
  // outputs
  output logic                      link_layer_reset_control_bit,
  output logic                      irq
);
  import err_log_pkg::*;

  logic [63:0]        error_bank_status_r;
  logic [IRQ_W-1:0]   irq_st_r, irq_en_r;
  logic               wr_pend_r, rd_pend_r;
  logic [7:0]         addr_r;
  logic [31:0]        hrdata_r;
  logic               llrst_r;

  // address phase capture
  wire                acc     = hsel & hready & htrans[1];
  wire                wr_now  = wr_pend_r;
  wire                wr_clr  = wr_now & (addr_r == CLEAR_ADDR);
  wire                wr_ien  = wr_now & (addr_r == IRQ_EN_ADDR);
  wire                wr_iclr = wr_now & (addr_r == IRQ_CLR_ADDR);
  wire                wr_llr  = wr_now & (addr_r == LLRST_ADDR);

  // current fields
  wire                valid   = error_bank_status_r[VALID_LSB+V_VAL];
  wire [5:0]          msc_q   = error_bank_status_r[MSC_LSB +: 6];
  wire [NFLAG-1:0]    flags_q = error_bank_status_r[FLAG_LSB +: NFLAG];
  wire [CNT_W-1:0]    cnt_q   = error_bank_status_r[CNT_LSB +: CNT_W];
  wire                any_ctrl = |ctrl_flag_pulse;
  wire                any_new  = any_ctrl | fault_rpt.other_err;

  // clear is write-any; a new control or other fault in the same cycle still lands (a corrected pulse is dropped), so
  // every decision below looks at the record as it stands after the clear
  wire [63:0]         base = wr_clr ? 64'h0 : error_bank_status_r;
  wire                base_v = base[VALID_LSB+V_VAL];
  wire [5:0]          base_msc = base[MSC_LSB +: 6];
  // fresh log when bank is empty; flags OR while code stays 12h
  wire                take_ctrl  = any_ctrl &
                                   (!base_v | base_msc == MSC_CTRL_ERR);
  wire                take_other = fault_rpt.other_err & !base_v & !any_ctrl;
  wire                overflow   = any_new & base_v & !take_ctrl;
  wire [CNT_W-1:0]    cnt_nxt = (corrected_pulse && cnt_q != {CNT_W{1'b1}}) ?
                                CNT_W'(cnt_q + 1'b1) : cnt_q;

  logic [63:0] stat_nxt;
  always_comb begin
    stat_nxt = base;
    stat_nxt[CNT_LSB +: CNT_W] = wr_clr ? {CNT_W{1'b0}} : cnt_nxt;
    if (take_ctrl) begin
      stat_nxt[ARCH_LSB +: 16] = ARCH_OTHER;
      stat_nxt[MSC_LSB +: 6]   = MSC_CTRL_ERR;
      // accumulate flags on the same log
      stat_nxt[FLAG_LSB +: NFLAG] = (base_v ? base[FLAG_LSB +: NFLAG] :
                                    {NFLAG{1'b0}}) | ctrl_flag_pulse;
      stat_nxt[VALID_LSB+V_VAL] = 1'b1;
      stat_nxt[VALID_LSB+V_UC]  = 1'b1;
      stat_nxt[VALID_LSB+V_EN]  = 1'b1;
    end else if (take_other | (fault_rpt.other_err & !base_v & !any_ctrl)) begin
      stat_nxt[ARCH_LSB +: 16] = fault_rpt.other_unsupp ? ARCH_UNSUPP :
                                 ARCH_OTHER;
      stat_nxt[MSC_LSB +: 6]   = fault_rpt.other_msc;
      stat_nxt[FLAG_LSB +: NFLAG] = {NFLAG{1'b0}};
      stat_nxt[INFO_LSB +: INFO_W] = fault_rpt.info;
      stat_nxt[VALID_LSB+V_VAL] = 1'b1;
      stat_nxt[VALID_LSB+V_UC]  = fault_rpt.other_uc;
      stat_nxt[VALID_LSB+V_EN]  = 1'b1;
    end
    if (overflow & base_v)
      stat_nxt[VALID_LSB+V_OVER] = 1'b1;
  end

  // status register, one bank of the interconnect group
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      error_bank_status_r <= 64'h0;
    end else begin
      error_bank_status_r <= stat_nxt;
    end
  end

  // flag view gated by code, never shows stale flags
  wire [NFLAG-1:0] flags_view = (msc_q == MSC_CTRL_ERR) ? flags_q :
                                {NFLAG{1'b0}};

  // interrupt events; set wins over clear
  wire [IRQ_W-1:0] ev;
  assign ev[EV_CTRL]  = take_ctrl;
  assign ev[EV_OTHER] = fault_rpt.other_err & !any_ctrl;
  assign ev[EV_OVER]  = overflow;
  wire [IRQ_W-1:0] iclr = wr_iclr ? hwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_r <= {IRQ_W{1'b0}};
      irq_en_r <= {IRQ_W{1'b0}};
      irq      <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~iclr) | ev;
      if (wr_ien)
        irq_en_r <= hwdata[IRQ_W-1:0];
      irq <= |(((irq_st_r & ~iclr) | ev) & (wr_ien ? hwdata[IRQ_W-1:0]
                                                   : irq_en_r));
    end
  end

  // link-layer reset bit: set by software, drops when reset completes;
  // software should not start phy training while it is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      llrst_r <= 1'b0;
    end else if (wr_llr && hwdata[0]) begin
      llrst_r <= 1'b1;
    end else if (link_reset_done) begin
      llrst_r <= 1'b0;
    end
  end
  assign link_layer_reset_control_bit = llrst_r;

  // registers that answer a read; the checks below reuse it for the
  // addresses that must read as zero
  function automatic logic is_readable(input logic [7:0] a);
    return (a == STAT_LO_ADDR) || (a == STAT_HI_ADDR) ||
           (a == IRQ_ST_ADDR) || (a == IRQ_EN_ADDR) || (a == LLRST_ADDR);
  endfunction

  // read data is chosen in the address phase so that it stands through
  // the data phase; limitation: a read right behind a write sees the
  // state from before that write lands
  wire [7:0] rd_addr = {haddr[7:2], 2'b00};
  wire [63:0] stat_view = {error_bank_status_r[63:32], flags_view,
                           error_bank_status_r[21:0]};
  logic [31:0] rd_mux;
  always_comb begin
    if (!is_readable(rd_addr))
      rd_mux = 32'h0;
    else if (rd_addr == STAT_LO_ADDR)
      rd_mux = stat_view[31:0];
    else if (rd_addr == STAT_HI_ADDR)
      rd_mux = stat_view[63:32];
    else if (rd_addr == IRQ_ST_ADDR)
      rd_mux = {{(32-IRQ_W){1'b0}}, irq_st_r};
    else if (rd_addr == IRQ_EN_ADDR)
      rd_mux = {{(32-IRQ_W){1'b0}}, irq_en_r};
    else
      rd_mux = {31'h0, llrst_r};
  end

  // bus phases: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      hrdata_r  <= 32'h0;
    end else begin
      wr_pend_r <= acc & hwrite;
      rd_pend_r <= acc & !hwrite;
      if (acc)
        addr_r <= {haddr[7:2], 2'b00};
      // held until the next read so the master may take it late
      if (acc && !hwrite)
        hrdata_r <= rd_mux;
    end
  end
  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // a control fault on an empty bank or a 12h record logs code 12h with its flag
  property ctrl_logs_p;
    @(posedge hclk) disable iff (!hresetn)
      (take_ctrl && !wr_clr) |=> (msc_q == MSC_CTRL_ERR) && valid
        && ((flags_q & $past(ctrl_flag_pulse)) == $past(ctrl_flag_pulse));
  endproperty
  ctrl_flag_log_a: assert property (ctrl_logs_p)
    else $error("control fault not logged with code 12h");

  flags_hidden_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (msc_q != MSC_CTRL_ERR) |-> flags_view == '0)
    else $error("detail flags visible under other code");

  arch_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
      valid |-> (error_bank_status_r[15:0] == ARCH_UNSUPP ||
                 error_bank_status_r[15:0] == ARCH_OTHER))
    else $error("bad architectural code logged");

  flags_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (valid && msc_q == MSC_CTRL_ERR && !wr_clr) |=>
        ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("detail flags lost before clear");

  clear_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_clr && !any_new) |=> !valid && flags_q == '0)
    else $error("status not cleared");

  llrst_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (link_reset_done && !wr_llr) |=> !llrst_r)
    else $error("link reset bit stuck high");

  sequence ovf_s;
    valid ##0 any_new ##0 !take_ctrl ##0 !wr_clr;
  endsequence
  ovf_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ovf_s |=> error_bank_status_r[VALID_LSB+V_OVER])
    else $error("overflow indicator not set");

  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (|(irq_st_r & irq_en_r)) |-> irq)
    else $error("interrupt not raised");

  // no enabled pending bit means the line is low
  irq_off_a: assert property (@(posedge hclk)
      disable iff (!hresetn) !(|(irq_st_r & irq_en_r)) |-> !irq)
    else $error("interrupt raised without cause");

  // each detail flag pulse lands on its own status bit
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi = gi + 1) begin : g_flag
      flag_bit_a: assert property (@(posedge hclk)
          disable iff (!hresetn)
          (ctrl_flag_pulse[gi] && take_ctrl && !wr_clr) |=>
            error_bank_status_r[FLAG_LSB+gi])
        else $error("detail flag bit not set");
    end
  endgenerate

  // stored flags only ever exist under the control-error code
  flags_store_a: assert property (@(posedge hclk)
      disable iff (!hresetn) (msc_q != MSC_CTRL_ERR) |-> flags_q == '0)
    else $error("detail flags stored under other code");

  // corrected count steps by one per pulse
  cnt_step_a: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (corrected_pulse && !wr_clr && cnt_q != {CNT_W{1'b1}}) |=>
        cnt_q == CNT_W'($past(cnt_q) + 1'b1))
    else $error("corrected count did not step");

  // saturation: a wrap would hide a storm of corrected errors
  cnt_hold_a: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (cnt_q == {CNT_W{1'b1}} && !wr_clr) |=> cnt_q == {CNT_W{1'b1}})
    else $error("corrected count wrapped");

  // a logged record keeps its codes until software clears it, save a control fault on a 12h record, which writes 0e0f
  code_kept_a: assert property (@(posedge hclk)
      disable iff (!hresetn) (valid && !wr_clr) |=>
        (msc_q == $past(msc_q) &&
         error_bank_status_r[15:0] == $past(error_bank_status_r[15:0])))
    else $error("logged codes changed before clear");

  // a control fault marks the record uncorrected and enabled
  ctrl_bits_a: assert property (@(posedge hclk)
      disable iff (!hresetn) (take_ctrl && !wr_clr) |=>
        (error_bank_status_r[VALID_LSB+V_UC] &&
         error_bank_status_r[VALID_LSB+V_EN]))
    else $error("validity bits of control fault wrong");

  // overflow and valid stay set until the clear
  over_sticky_a: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (error_bank_status_r[VALID_LSB+V_OVER] && !wr_clr) |=>
        (error_bank_status_r[VALID_LSB+V_OVER] && valid))
    else $error("overflow indicator dropped");

  // a non-control fault on an empty bank logs its own code and info
  sequence other_take_s;
    take_other ##0 !wr_clr;
  endsequence
  sequence other_rec_s;
    (msc_q == $past(fault_rpt.other_msc)) ##0
      (error_bank_status_r[INFO_LSB +: INFO_W] == $past(fault_rpt.info));
  endsequence
  other_log_a: assert property (@(posedge hclk)
      disable iff (!hresetn) other_take_s |=> other_rec_s)
    else $error("other fault record wrong");

  // an interrupt event sets its bit even when cleared in the same cycle
  irq_set_a: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (|ev) |=> ((irq_st_r & $past(ev)) == $past(ev)))
    else $error("interrupt event lost");

  // clearing with no event pending drops the chosen bits
  irq_clr_a: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_iclr && ev == '0) |=> ((irq_st_r & $past(iclr)) == '0))
    else $error("interrupt status not cleared");

  // software raises the link reset bit by writing one
  llrst_set_a: assert property (@(posedge hclk)
      disable iff (!hresetn) (wr_llr && hwdata[0]) |=> llrst_r)
    else $error("link reset bit not set");

  // unmapped reads return zero in their data phase
  unmapped_a: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (rd_pend_r && !is_readable(addr_r)) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");

endmodule

// file: err_log_pkg.sv
// shared constants and types for the interconnect error status log
package err_log_pkg;

  // register byte addresses
  localparam logic [7:0] STAT_LO_ADDR = 8'h00;
  localparam logic [7:0] STAT_HI_ADDR = 8'h04;
  localparam logic [7:0] CLEAR_ADDR   = 8'h08;
  localparam logic [7:0] IRQ_ST_ADDR  = 8'h0c;
  localparam logic [7:0] IRQ_EN_ADDR  = 8'h10;
  localparam logic [7:0] IRQ_CLR_ADDR = 8'h14;
  localparam logic [7:0] LLRST_ADDR   = 8'h18;

  // status field layout
  localparam int ARCH_LSB  = 0;
  localparam int MSC_LSB   = 16;
  localparam int FLAG_LSB  = 22;
  localparam int INFO_LSB  = 32;
  localparam int CNT_LSB   = 38;
  localparam int VALID_LSB = 57;
  localparam int NFLAG     = 10;
  localparam int CNT_W     = 19;
  localparam int INFO_W    = 6;

  // codes
  localparam logic [5:0]  MSC_CTRL_ERR = 6'h12;
  localparam logic [15:0] ARCH_UNSUPP  = 16'h0c0f;
  localparam logic [15:0] ARCH_OTHER   = 16'h0e0f;

  // validity indicator bits inside 63:57
  localparam int V_VAL  = 6;
  localparam int V_OVER = 5;
  localparam int V_UC   = 4;
  localparam int V_EN   = 3;

  // interrupt event bits
  localparam int IRQ_W    = 3;
  localparam int EV_CTRL  = 0;
  localparam int EV_OTHER = 1;
  localparam int EV_OVER  = 2;

  // one-cycle fault report from the link and phy layers
  typedef struct packed {
    logic                     other_err;
    logic                     other_unsupp;
    logic                     other_uc;
    logic [5:0]               other_msc;
    logic [INFO_W-1:0]        info;
  } fault_rpt_t;

endpackage

// file: link_peer.sv
// peer link agent model that raises fault reports toward the bank
`timescale 1ns/1ps
module link_peer (
  // clock
  input  wire logic                    hclk,
  // fault reports toward the bank
  output logic [err_log_pkg::NFLAG-1:0] ctrl_flag_pulse,
  output logic                         corrected_pulse,
  output err_log_pkg::fault_rpt_t      fault_rpt,
  output logic                         link_reset_done
);
  import err_log_pkg::*;
  fault_rpt_t r;
  initial begin
    ctrl_flag_pulse = '0;
    corrected_pulse = 1'b0;
    fault_rpt = '0;
    link_reset_done = 1'b0;
  end
  // control fault flags, one cycle wide
  task automatic ctrl(input logic [NFLAG-1:0] f);
    @(posedge hclk) ctrl_flag_pulse <= f;
    @(posedge hclk) ctrl_flag_pulse <= '0;
  endtask
  // corrected event, one cycle wide
  task automatic corr();
    @(posedge hclk) corrected_pulse <= 1'b1;
    @(posedge hclk) corrected_pulse <= 1'b0;
  endtask
  // other fault; fields scrambled after the pulse so nothing stale stays
  task automatic other(input logic u, input logic [5:0] m, input logic [5:0] i);
    r = '{other_err:1'b1, other_unsupp:u, other_uc:1'b1, other_msc:m, info:i};
    @(posedge hclk) fault_rpt <= r;
    r = ~r;
    r.other_err = 1'b0;
    @(posedge hclk) fault_rpt <= r;
  endtask
  // link reset completion, one cycle wide
  task automatic rst_done();
    @(posedge hclk) link_reset_done <= 1'b1;
    @(posedge hclk) link_reset_done <= 1'b0;
  endtask
endmodule

// file: tb.sv
// self-checking bench for the interconnect error status log
`timescale 1ns/1ps
module tb;
  import err_log_pkg::*;
  logic                    hclk = 1'b0;
  logic                    hresetn = 1'b0;
  logic                    hsel = 1'b0;
  logic                    hwrite = 1'b0;
  logic [7:0]              haddr;
  logic [1:0]              htrans;
  logic [2:0]              hsize;
  logic [31:0]             hwdata;
  logic [31:0]             hrdata;
  logic [31:0]             rd;
  logic                    hready;
  logic                    hreadyout;
  logic                    hresp;
  logic [NFLAG-1:0]        ctrl_flag_pulse;
  logic                    corrected_pulse;
  fault_rpt_t              fault_rpt;
  logic                    link_reset_done;
  logic                    link_layer_reset_control_bit;
  logic                    irq;
  int                      err_count = 0;
  int                      compares = 0;
  int                      seed = 32'h58df48f9;
  int                      flags;
  int                      m;
  int                      inf;
  logic [7:0]              regs [6] = '{STAT_LO_ADDR, STAT_HI_ADDR,
                             IRQ_ST_ADDR, IRQ_EN_ADDR, LLRST_ADDR, 8'h1c};
  always #4 hclk = ~hclk;
  assign hready = hreadyout;
  interconnect_error_status_log dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ctrl_flag_pulse(ctrl_flag_pulse),
    .corrected_pulse(corrected_pulse), .fault_rpt(fault_rpt),
    .link_reset_done(link_reset_done),
    .link_layer_reset_control_bit(link_layer_reset_control_bit), .irq(irq));
  link_peer peer_u (.hclk(hclk), .ctrl_flag_pulse(ctrl_flag_pulse),
    .corrected_pulse(corrected_pulse), .fault_rpt(fault_rpt),
    .link_reset_done(link_reset_done));
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // single word transfer; each phase waits for ready under a bound
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
        if (n > 20) begin
          err_count++;
          conclude();
        end
      end while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
    end
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // expected low word of a control fault record
  function automatic logic [31:0] exp_lo(input int f);
    return {f[9:0], MSC_CTRL_ERR, ARCH_OTHER};
  endfunction
  task automatic irq_is(input logic v);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, {31'h0, v});
  endtask
  initial begin
    haddr = 8'h00;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[j]) rdc(regs[j], 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    $display("test reset done");
    for (int k = 0; k < NFLAG; k++) begin
      bus(1'b1, CLEAR_ADDR, 32'h0);
      peer_u.ctrl(10'h1 << k);
      rdc(STAT_LO_ADDR, exp_lo(1 << k));
    end
    $display("test flags done");
    bus(1'b1, CLEAR_ADDR, 32'h0);
    flags = 0;
    repeat (3) begin
      m = 1 << ({$random(seed)} % NFLAG);
      flags |= m;
      peer_u.ctrl(m[9:0]);
    end
    rdc(STAT_LO_ADDR, exp_lo(flags));
    $display("test accumulate done");
    bus(1'b1, IRQ_CLR_ADDR, 32'h7);
    bus(1'b1, CLEAR_ADDR, 32'h0);
    m = $random(seed) & 32'h0f;
    inf = $random(seed) & 32'h3f;
    peer_u.other(1'b1, m[5:0], inf[5:0]);
    peer_u.ctrl(10'h3ff);
    rdc(STAT_LO_ADDR, {10'h0, m[5:0], ARCH_UNSUPP});
    bus(1'b0, STAT_HI_ADDR, 32'h0);
    chk(rd & 32'he000003f, 32'he0000000 | inf);
    rdc(IRQ_ST_ADDR, 32'h6);
    bus(1'b1, CLEAR_ADDR, 32'h0);
    peer_u.other(1'b0, m[5:0], inf[5:0]);
    rdc(STAT_LO_ADDR, {10'h0, m[5:0], ARCH_OTHER});
    $display("test other done");
    bus(1'b1, CLEAR_ADDR, 32'h0);
    repeat (3) peer_u.corr();
    bus(1'b0, STAT_HI_ADDR, 32'h0);
    chk((rd >> 6) & 32'h7ffff, 32'h3);
    $display("test count done");
    bus(1'b1, CLEAR_ADDR, 32'h0);
    bus(1'b1, IRQ_CLR_ADDR, 32'h7);
    bus(1'b1, IRQ_EN_ADDR, 32'h1);
    rdc(IRQ_EN_ADDR, 32'h1);
    peer_u.ctrl(10'h1);
    irq_is(1'b1);
    rdc(IRQ_ST_ADDR, 32'h1);
    bus(1'b1, IRQ_CLR_ADDR, 32'h1);
    irq_is(1'b0);
    bus(1'b1, IRQ_EN_ADDR, 32'h0);
    peer_u.ctrl(10'h2);
    irq_is(1'b0);
    rdc(IRQ_ST_ADDR, 32'h1);
    $display("test irq done");
    bus(1'b1, LLRST_ADDR, 32'h1);
    rdc(LLRST_ADDR, 32'h1);
    chk({31'h0, link_layer_reset_control_bit}, 32'h1);
    peer_u.rst_done();
    rdc(LLRST_ADDR, 32'h0);
    $display("test link reset done");
    conclude();
  end
endmodule
